// [hw/dcm_cfg.svh]
/*
  Constants for the data cache maintenance block: address fields,
  result layout, register offsets and reset values.
  Assumes a 32-bit effective address; every position here counts from
  the least significant bit, bit 0.
*/
`ifndef DCM_CFG_SVH
`define DCM_CFG_SVH

// ==========================================================
// Effective address fields
`define DCM_TAG_HI    31
`define DCM_TAG_LO    12
`define DCM_CLS_HI    13
`define DCM_CLS_LO    5
`define DCM_WRD_HI    4
`define DCM_WRD_LO    2
`define DCM_ALN_HI    1
`define DCM_ALN_LO    0

// ==========================================================
// Tag read result fields
`define DCM_RES_DIRTY 5
`define DCM_RES_VALID 4
`define DCM_RES_LRU   0

// ==========================================================
// Register offsets and reset values
`define DCM_OFF_CFG   4'h0
`define DCM_OFF_STAT  4'h1
`define DCM_CFG_ARR   0
`define DCM_CFG_WAY   1
`define DCM_CFG_RST   2'h0

`endif

// [hw/dcm_pkg.sv]
/*
  Types shared by the data cache maintenance block.
  Assumes the constants header is included beside it.
*/
package dcm_pkg;

    // ==========================================================
    // Operation kinds issued by the pipeline
    typedef enum logic {
        DCM_OP_INVAL,
        DCM_OP_READ
    } dcm_op_t;

    // ==========================================================
    // Outcome of one operation
    typedef enum logic [2:0] {
        DCM_RES_OK,
        DCM_RES_PRIV,
        DCM_RES_ALIGN,
        DCM_RES_TLB
    } dcm_res_t;

endpackage

// [hw/dcm_top.sv]
/*
  Data cache maintenance: congruence class invalidate and debug read
  of a two-way data cache whose arrays live in this module.
  Assumes the pipeline supplies operands and privilege in the issue
  cycle, and that the translation unit answers a miss in that cycle.
  Limitation: tag and data arrays are not reset, so a debug read of a
  line that was never filled returns unknown data; startup software
  invalidates every class before it turns cachability on.
*/
`timescale 1ns/10ps
`include "dcm_cfg.svh"

module dcm_top
    import dcm_pkg::*;
#(
    parameter int CLS_BITS = 9,
    parameter int WRD_BITS = 3
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Operation issue from the pipeline
    input  wire logic        op_valid,
    input  wire dcm_op_t     op_kind,
    input  wire logic [4:0]  base_reg_field,
    input  wire logic [4:0]  target_reg_field,
    input  wire logic [31:0] base_val,
    input  wire logic [31:0] index_val,
    input  wire logic        privileged,
    input  wire logic        rc_bit,
    input  wire logic        cachable,
    // Translation and address compare
    output logic [31:0]      eff_addr,
    output logic             xlat_req,
    output logic             prot_is_load,
    input  wire logic        tlb_miss,
    input  wire logic        dac_load_match,
    // Operation outcome, one cycle after issue
    output logic             op_done,
    output dcm_res_t         op_result,
    output logic             gpr_wr,
    output logic [4:0]       gpr_field,
    output logic [31:0]      gpr_data,
    output logic             first_condition_field_undef,
    output logic             dac_event,
    // Normal access lookup
    input  wire logic [31:0] lk_addr,
    output logic             lk_hit,
    output logic             lk_way,
    // Line refill and word write
    input  wire logic        alloc_en,
    input  wire logic        alloc_way,
    input  wire logic [31:0] alloc_addr,
    input  wire logic        word_en,
    input  wire logic        word_way,
    input  wire logic [31:0] word_addr,
    input  wire logic [31:0] word_data,
    input  wire logic        word_dirty,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);

    localparam int NCLS = 1 << CLS_BITS;
    localparam int NWRD = NCLS << WRD_BITS;
    localparam int TAGW = `DCM_TAG_HI - `DCM_TAG_LO + 1;

    // ==========================================================
    // Cache arrays, per way
    logic [31:0]     data_mem [2][NWRD];
    logic [TAGW-1:0] tag_mem  [2][NCLS];
    // State bits are flops so that reset and an invalidate clear a class
    logic [NCLS-1:0] valid_bits [2];
    logic [NCLS-1:0] dirty_bits [2];
    logic [NCLS-1:0] lru_bits;

    // Core configuration and status
    logic [1:0]  core_config_reg;
    dcm_res_t    last_result;
    logic [7:0]  op_count;

    // ==========================================================
    // Effective address and its fields
    wire  [31:0]         base_sel;
    wire  [CLS_BITS-1:0] cls;
    wire  [CLS_BITS+WRD_BITS-1:0] wrd_idx;
    wire                 array_select;
    wire                 way_select;

    // The base field itself, not the register it names, picks a zero base
    assign base_sel = (base_reg_field == 5'h00) ? 32'h0 : base_val;
    assign eff_addr = base_sel + index_val;
    assign cls      = eff_addr[`DCM_CLS_HI:`DCM_CLS_LO];
    assign wrd_idx  = {cls, eff_addr[`DCM_WRD_HI:`DCM_WRD_LO]};
    assign array_select = core_config_reg[`DCM_CFG_ARR];
    assign way_select   = core_config_reg[`DCM_CFG_WAY];

    // ==========================================================
    // Translation request; protection always evaluated as a load
    // No data moves, but a miss at the address is still reported
    assign xlat_req     = op_valid;
    assign prot_is_load = op_valid;

    // ==========================================================
    // Exception decode, privilege first, then alignment, then TLB
    wire      is_read;
    wire      misalign;
    wire      ok;
    dcm_res_t next_result;

    // A refused operation touches neither the arrays nor the target
    assign is_read  = (op_kind == DCM_OP_READ);
    assign misalign = is_read &&
                      (eff_addr[`DCM_ALN_HI:`DCM_ALN_LO] != 2'h0);
    assign next_result = !privileged ? DCM_RES_PRIV :
                         misalign    ? DCM_RES_ALIGN :
                         tlb_miss    ? DCM_RES_TLB : DCM_RES_OK;
    assign ok = op_valid && (next_result == DCM_RES_OK);

    // Cachable attribute deliberately plays no part in the decision
    wire do_inval;
    wire do_read;
    wire unused_cachable;

    assign do_inval = ok && !is_read;
    assign do_read  = ok && is_read;
    assign unused_cachable = cachable;

    // ==========================================================
    // Debug read selection: data word or tag image of one way
    wire [31:0] sel_data;
    wire [31:0] sel_tag;
    wire [31:0] next_gpr;

    // Reserved result bits read as zero; arrays hold unknowns until filled
    assign sel_data = data_mem[way_select][wrd_idx];
    assign sel_tag  = {tag_mem[way_select][cls],
                       6'h00,
                       dirty_bits[way_select][cls],
                       valid_bits[way_select][cls],
                       3'h0,
                       lru_bits[cls]};
    assign next_gpr = array_select ? sel_tag : sel_data;

    // ==========================================================
    // Next values of the outcome registers
    wire      next_gpr_wr;
    wire      next_undef;
    wire      next_dac;
    dcm_res_t next_op_result;

    // Idle cycles report OK, so a stale refusal never lingers
    assign next_op_result = op_valid ? next_result : DCM_RES_OK;
    // gpr_data holds between reads; only gpr_wr marks a fresh value
    assign next_gpr_wr    = do_read;
    // Flag only; the condition field is simply not refreshed
    assign next_undef     = ok && rc_bit;
    // Only the debug read, as a load, may hit a compare
    assign next_dac       = do_read && dac_load_match;

    // ==========================================================
    // Outcome registers, standing for one cycle after issue
    always_ff @(posedge clock) begin
        if (rst) begin
            op_done   <= 1'b0;
            op_result <= DCM_RES_OK;
            gpr_wr    <= 1'b0;
            gpr_field <= 5'h00;
            gpr_data  <= 32'h0;
            first_condition_field_undef <= 1'b0;
            dac_event <= 1'b0;
        end else begin
            op_done   <= op_valid;
            op_result <= next_op_result;
            gpr_wr    <= next_gpr_wr;
            gpr_field <= target_reg_field;
            if (do_read) begin
                gpr_data <= next_gpr;
            end
            first_condition_field_undef <= next_undef;
            dac_event <= next_dac;
        end
    end

    // ==========================================================
    // Normal lookup: invalid lines never hit
    wire [CLS_BITS-1:0] lk_cls;
    wire [TAGW-1:0]     lk_tag;
    wire [1:0]          lk_match;

    assign lk_cls = lk_addr[`DCM_CLS_HI:`DCM_CLS_LO];
    assign lk_tag = lk_addr[`DCM_TAG_HI:`DCM_TAG_LO];

    // One comparator per way; an invalid line never compares
    genvar w;
    generate
        for (w = 0; w < 2; w++) begin : gen_way
            assign lk_match[w] = valid_bits[w][lk_cls] &&
                                 (tag_mem[w][lk_cls] == lk_tag);
        end
    endgenerate

    // Replacement follows every hit on this port except in a refill cycle, so a lookup held on one
    // class keeps it pointing at the other way
    assign lk_hit = |lk_match;
    assign lk_way = lk_match[1];

    // ==========================================================
    // Refill and word write addresses
    wire [CLS_BITS-1:0]          al_cls;
    wire [CLS_BITS-1:0]          wd_cls;
    wire [CLS_BITS+WRD_BITS-1:0] wd_idx;

    assign al_cls = alloc_addr[`DCM_CLS_HI:`DCM_CLS_LO];
    assign wd_cls = word_addr[`DCM_CLS_HI:`DCM_CLS_LO];
    assign wd_idx = {wd_cls, word_addr[`DCM_WRD_HI:`DCM_WRD_LO]};

    // A refill writes only the tag; its data words arrive on the word port
    // Storage arrays: no reset, far too large and not needed
    always_ff @(posedge clock) begin
        if (alloc_en) begin
            tag_mem[alloc_way][al_cls] <= alloc_addr[`DCM_TAG_HI:`DCM_TAG_LO];
        end
        if (word_en) begin
            data_mem[word_way][wd_idx] <= word_data;
        end
    end

    // ==========================================================
    // Valid, dirty and replacement state. The invalidate is the last
    // assignment, so it wins over a refill of the same class in the
    // same cycle; the refill must be retried.
    always_ff @(posedge clock) begin
        if (rst) begin
            valid_bits[0] <= '0;
            valid_bits[1] <= '0;
            dirty_bits[0] <= '0;
            dirty_bits[1] <= '0;
            lru_bits      <= '0;
        end else begin
            if (alloc_en) begin
                valid_bits[alloc_way][al_cls] <= 1'b1;
                dirty_bits[alloc_way][al_cls] <= 1'b0;
                lru_bits[al_cls]              <= ~alloc_way;
            end
            if (word_en && word_dirty) begin
                dirty_bits[word_way][wd_cls] <= 1'b1;
            end
            if (lk_hit && !alloc_en) begin
                lru_bits[lk_cls] <= ~lk_way;                          // Other way now older
            end
            // Clears the class whatever its tags hold; lookups miss next cycle
            if (do_inval) begin
                // Dirty data is dropped, nothing is written back
                valid_bits[0][cls] <= 1'b0;
                valid_bits[1][cls] <= 1'b0;
                dirty_bits[0][cls] <= 1'b0;
                dirty_bits[1][cls] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Register port decode; unmapped offsets read as zero, ignore writes
    wire        hit_cfg;
    wire        hit_stat;
    wire        cfg_wr;
    wire [31:0] stat_word;
    wire [31:0] next_rdata;
    wire [7:0]  next_op_count;

    assign hit_cfg    = (reg_addr == `DCM_OFF_CFG);
    assign hit_stat   = (reg_addr == `DCM_OFF_STAT);
    assign cfg_wr     = reg_wr && hit_cfg;
    assign stat_word  = {21'h0, op_count, last_result};
    assign next_rdata = hit_cfg  ? {30'h0, core_config_reg} :
                        hit_stat ? stat_word : 32'h0;
    // Counts every issue, refused or not; wraps freely
    assign next_op_count = op_count + 8'h01;

    // Configuration write and status tracking
    always_ff @(posedge clock) begin
        if (rst) begin
            core_config_reg <= `DCM_CFG_RST;
            last_result     <= DCM_RES_OK;
            op_count        <= 8'h00;
            reg_rdata       <= 32'h0;
        end else begin
            if (cfg_wr) begin
                core_config_reg <= reg_wdata[1:0];
            end
            // Status follows every issue so software can see a refusal
            if (op_valid) begin
                last_result <= next_result;
                op_count    <= next_op_count;
            end
            // Read data stands only in the cycle after the strobe
            reg_rdata <= reg_rd ? next_rdata : 32'h0;
        end
    end

endmodule

// [bench/dcm_xlat_model.sv]
/*
  Translation and address compare model facing the maintenance block.
  Assumes both answers are wanted in the issue cycle.
*/
`timescale 1ns/10ps
module dcm_xlat_model #(
    parameter logic [31:0] DAC_ADDR = 32'h7777_7460
) (
    // Request from the block
    input  wire logic [31:0] eff_addr,
    input  wire logic        xlat_req,
    // Answers
    output logic             tlb_miss,
    output logic             dac_load_match
);
    // Top page unmapped; one watched load word
    assign tlb_miss       = xlat_req && (eff_addr[31:28] == 4'hf);
    assign dac_load_match = xlat_req && (eff_addr == DAC_ADDR);
endmodule

// [bench/dcm_monitor.sv]
/*
  Checker on the top ports of the cache maintenance block.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module dcm_monitor
    import dcm_pkg::*;
#(
    parameter int CLS_BITS = 9
) (
    // Watched ports
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        op_valid,
    input wire dcm_op_t     op_kind,
    input wire logic        privileged,
    input wire logic        tlb_miss,
    input wire logic [31:0] eff_addr,
    input wire logic [4:0]  target_reg_field,
    input wire logic        prot_is_load,
    input wire logic        op_done,
    input wire dcm_res_t    op_result,
    input wire logic        gpr_wr,
    input wire logic [4:0]  gpr_field,
    input wire logic        dac_event,
    input wire logic [31:0] lk_addr,
    input wire logic        lk_hit
);
    // ==========================================================
    // Issue classes
    wire logic bad_aln = op_valid && privileged && op_kind == DCM_OP_READ && eff_addr[1:0] != 2'h0;
    wire logic op_ok   = op_valid && privileged && !tlb_miss && !bad_aln;
    logic [CLS_BITS-1:0] inv_cls;
    // Class of the previous cycle's address, so the miss check needs no $past of a slice
    always_ff @(posedge clock) begin
        inv_cls <= eff_addr[CLS_BITS+4:5];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_inval; op_ok && op_kind == DCM_OP_INVAL; endsequence
    sequence s_read; op_ok && op_kind == DCM_OP_READ; endsequence
    // ==========================================================
    // Properties
    property p_done; op_valid |-> prot_is_load ##1 op_done; endproperty
    a_done: assert property (p_done) else $error("no done after issue");
    property p_idle; !op_valid |=> !op_done && op_result == DCM_RES_OK && !gpr_wr; endproperty
    a_idle: assert property (p_idle) else $error("outcome without issue");
    property p_priv; op_valid && !privileged |=> op_result == DCM_RES_PRIV && !gpr_wr; endproperty
    a_priv: assert property (p_priv) else $error("user issue accepted");
    property p_align; bad_aln |=> op_result == DCM_RES_ALIGN && !gpr_wr; endproperty
    a_align: assert property (p_align) else $error("misaligned read accepted");
    property p_tlb; op_valid && privileged && !bad_aln && tlb_miss |=> op_result == DCM_RES_TLB;
    endproperty
    a_tlb: assert property (p_tlb) else $error("miss not reported");
    property p_read;
        s_read |=> gpr_wr && op_result == DCM_RES_OK && gpr_field == $past(target_reg_field);
    endproperty
    a_read: assert property (p_read) else $error("read not written back");
    property p_nodac; op_valid && op_kind == DCM_OP_INVAL |=> !dac_event; endproperty
    a_nodac: assert property (p_nodac) else $error("compare event on invalidate");
    property p_miss; s_inval ##1 (lk_addr[CLS_BITS+4:5] == inv_cls) |-> !lk_hit; endproperty
    a_miss: assert property (p_miss) else $error("hit in cleared class");
endmodule

bind dcm_top dcm_monitor #(.CLS_BITS(CLS_BITS)) mon_u (
    .clock(clock), .rst(rst), .op_valid(op_valid), .op_kind(op_kind),
    .privileged(privileged), .tlb_miss(tlb_miss), .eff_addr(eff_addr),
    .target_reg_field(target_reg_field), .prot_is_load(prot_is_load), .op_done(op_done),
    .op_result(op_result), .gpr_wr(gpr_wr), .gpr_field(gpr_field),
    .dac_event(dac_event), .lk_addr(lk_addr), .lk_hit(lk_hit));

// [bench/tb_dcache_invalidate_debug_read.sv]
/*
  Bench for the cache maintenance block: a table of debug reads, then
  refusals, compare events and a class invalidate.
  Assumes the translation model answers in the issue cycle.
*/
`timescale 1ns/10ps
module tb_dcache_invalidate_debug_read
    import dcm_pkg::*;
;
    typedef struct packed {
        logic [1:0]  cfg;
        logic [4:0]  bf;
        logic [31:0] b;
        logic [31:0] i;
        logic [31:0] e;
    } dcm_row_t;
    logic        clock, rst, op_valid, privileged, rc_bit, cachable, alloc_en, alloc_way;
    logic        word_en, word_way, word_dirty, reg_wr, reg_rd, xlat_req, prot_is_load;
    logic        tlb_miss, dac_load_match, op_done, gpr_wr, undef, dac_event, lk_hit, lk_way;
    dcm_op_t     op_kind;
    dcm_res_t    op_result;
    logic [3:0]  reg_addr;
    logic [4:0]  base_reg_field, target_reg_field, gpr_field;
    logic [31:0] base_val, index_val, lk_addr, alloc_addr, word_addr, word_data;
    logic [31:0] reg_wdata, reg_rdata, eff_addr, gpr_data, rd;
    int          err_count, comparisons;
    // Reads of a class holding a dirty way A and a clean way B
    dcm_row_t rows [4] = '{
        '{2'h0, 5'h00, 32'hffff_0000, 32'h0012_346c, 32'hcafe_0003},
        '{2'h0, 5'h04, 32'h0012_0000, 32'h0000_346c, 32'hcafe_0003},
        '{2'h1, 5'h07, 32'h0010_0000, 32'h0002_3460, 32'h0012_3030},
        '{2'h3, 5'h00, 32'h0000_0000, 32'h00ab_f460, 32'h00ab_f010}};

    dcm_top dut_u (
        .clock(clock), .rst(rst), .op_valid(op_valid), .op_kind(op_kind),
        .base_reg_field(base_reg_field), .target_reg_field(target_reg_field),
        .base_val(base_val), .index_val(index_val), .privileged(privileged),
        .rc_bit(rc_bit), .cachable(cachable), .eff_addr(eff_addr), .xlat_req(xlat_req),
        .prot_is_load(prot_is_load), .tlb_miss(tlb_miss), .dac_load_match(dac_load_match),
        .op_done(op_done), .op_result(op_result), .gpr_wr(gpr_wr), .gpr_field(gpr_field),
        .gpr_data(gpr_data), .first_condition_field_undef(undef), .dac_event(dac_event),
        .lk_addr(lk_addr), .lk_hit(lk_hit), .lk_way(lk_way), .alloc_en(alloc_en),
        .alloc_way(alloc_way), .alloc_addr(alloc_addr), .word_en(word_en),
        .word_way(word_way), .word_addr(word_addr), .word_data(word_data),
        .word_dirty(word_dirty), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    dcm_xlat_model xlat_u (.eff_addr(eff_addr), .xlat_req(xlat_req),
        .tlb_miss(tlb_miss), .dac_load_match(dac_load_match));

    // ==========================================================
    // Clock, checks and bus tasks
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One strobe cycle; read data land in the following cycle only
    task automatic reg_op(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        {reg_wr, reg_rd} <= 2'b00;
        #1 rd = reg_rdata;
    endtask
    // Issue one operation and sample its outcome cycle
    task automatic op(input dcm_op_t k, input logic [4:0] f, input logic [31:0] b,
                      input logic [31:0] i, input logic p, input logic r);
        @(posedge clock);
        op_valid <= 1'b1;
        op_kind <= k;
        base_reg_field <= f;
        base_val <= b;
        index_val <= i;
        privileged <= p;
        rc_bit <= r;
        @(posedge clock);
        op_valid <= 1'b0;
        #1;
    endtask
    task automatic refuse(input dcm_op_t k, input logic [31:0] i, input logic p,
                          input dcm_res_t r);
        op(k, 5'h00, 32'h0, i, p, 1'b0);
        chk(op_result, r);
        chk(gpr_wr, 1'b0);
    endtask
    // Refill (ae high) or one dirty word write (ae low)
    task automatic fill(input logic ae, input logic w, input logic [31:0] a,
                        input logic [31:0] d);
        @(posedge clock);
        {alloc_en, word_en, alloc_way, word_way} <= {ae, !ae, w, w};
        {alloc_addr, word_addr, word_data} <= {a, a, d};
        @(posedge clock);
        {alloc_en, word_en} <= 2'b00;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {op_valid, privileged, rc_bit, alloc_en, alloc_way, word_en, word_way} = '0;
        {reg_wr, reg_rd, base_reg_field, base_val, index_val, alloc_addr} = '0;
        {word_addr, word_data, reg_addr, reg_wdata} = '0;
        op_kind = DCM_OP_INVAL;
        {cachable, word_dirty, target_reg_field, rst} = 8'hdb;
        lk_addr = 32'h00ab_f460;
        {err_count, comparisons} = '0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        reg_op(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0);
        chk(op_done, 1'b0);
        for (int c = 0; c < 512; c++) op(DCM_OP_INVAL, 5'h00, 32'h0, c << 5, 1'b1, 1'b0);
        fill(1'b1, 1'b0, 32'h0012_3460, 32'h0);
        fill(1'b0, 1'b0, 32'h0012_346c, 32'hcafe_0003);
        fill(1'b1, 1'b1, 32'h00ab_f460, 32'h0);
        #1 chk({lk_hit, lk_way}, 2'b11);
        foreach (rows[n]) begin
            reg_op(1'b1, 4'h0, {30'h0, rows[n].cfg});
            op(DCM_OP_READ, rows[n].bf, rows[n].b, rows[n].i, 1'b1, 1'b0);
            chk(gpr_data, rows[n].e);
            chk({op_result, gpr_wr, gpr_field}, {DCM_RES_OK, 6'h2d});
        end
        refuse(DCM_OP_READ, 32'h0012_3462, 1'b1, DCM_RES_ALIGN);
        refuse(DCM_OP_READ, 32'hf012_3461, 1'b0, DCM_RES_PRIV);
        refuse(DCM_OP_READ, 32'hf000_0000, 1'b1, DCM_RES_TLB);
        refuse(DCM_OP_INVAL, 32'hf000_0000, 1'b1, DCM_RES_TLB);
        refuse(DCM_OP_INVAL, 32'h7777_7460, 1'b0, DCM_RES_PRIV);
        chk(lk_hit, 1'b1);
        op(DCM_OP_READ, 5'h00, 32'h0, 32'h7777_7460, 1'b1, 1'b1);
        chk({dac_event, undef, gpr_wr}, 3'b111);
        @(posedge clock) cachable <= 1'b0;
        op(DCM_OP_INVAL, 5'h03, 32'h7777_0000, 32'h0000_7460, 1'b1, 1'b1);
        chk({op_result, dac_event, undef, lk_hit}, {DCM_RES_OK, 3'b010});
        @(posedge clock) lk_addr <= 32'h0012_3460;
        #1 chk(lk_hit, 1'b0);
        for (int w = 0; w < 2; w++) begin
            reg_op(1'b1, 4'h0, {30'h0, w[0], 1'b1});
            op(DCM_OP_READ, 5'h00, 32'h0, 32'h0012_3460, 1'b1, 1'b0);
            chk(gpr_data[5:4], 2'h0);
        end
        reg_op(1'b0, 4'h1, 32'h0);
        chk(rd[2:0], DCM_RES_OK);
        chk(rd[10:3], 8'h0d);
        reg_op(1'b0, 4'h9, 32'h0);
        chk(rd, 32'h0);
        // Mid-run reset clears line state and configuration
        reg_op(1'b1, 4'h0, 32'h3);
        fill(1'b1, 1'b0, 32'h0012_3460, 32'h0);
        #1 chk(lk_hit, 1'b1);
        @(posedge clock) rst <= 1'b1;
        @(posedge clock) rst <= 1'b0;
        #1 chk({lk_hit, op_done}, 2'b00);
        reg_op(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h0);
        tally_and_finish();
    end
    // Watchdog well past the expected run of about 1100 cycles
    initial begin
        repeat (5000) @(posedge clock);
        err_count++;
        tally_and_finish();
    end
endmodule
